// [logic/miex_pkg.sv]
// Package of offsets, field layouts, opcodes and constants for the instruction execute unit.
package miex_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFF_CMD = 10'h000;
  localparam logic [9:0] OFF_OPND = 10'h004;
  localparam logic [9:0] OFF_ACC = 10'h008;
  localparam logic [9:0] OFF_STATUS = 10'h00C;
  localparam logic [9:0] OFF_PC = 10'h010;
  localparam logic [9:0] OFF_WDT = 10'h014;
  localparam logic [9:0] OFF_STACK = 10'h018;
  localparam logic [1:0] MEM_PAGE = 2'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int OPND_ADDR_LSB = 0;
  localparam int OPND_TGT_LSB = 16;
  localparam int ST_Z = 0;
  localparam int ST_C = 1;
  localparam int ST_AC = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  localparam int ST_BUSY = 8;
  localparam int ST_HALT = 9;
  localparam int ST_PRE1 = 10;
  localparam int ST_PRE2 = 11;
  localparam int PC_SP_LSB = 16;

  // ----------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int MADDR_W = 6;
  localparam int SP_W = 4;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] NIB_LIMIT = 4'h9;
  localparam logic [4:0] NIB_ADJ = 5'h06;
  localparam logic [3:0] MACHINE_CLKS = 4'h4;
  localparam logic [MADDR_W-1:0] PCL_IDX = 6'h02;

  // ----------------------------------------------------------------
  // Opcodes and states
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_AND_M = 5'h01;
  localparam logic [4:0] OP_AND_I = 5'h02;
  localparam logic [4:0] OP_AND_INTO_MEMORY_OP = 5'h03;
  localparam logic [4:0] OP_OR_M = 5'h04;
  localparam logic [4:0] OP_OR_I = 5'h05;
  localparam logic [4:0] OP_ORM = 5'h06;
  localparam logic [4:0] OP_CALL = 5'h07;
  localparam logic [4:0] OP_JMP = 5'h08;
  localparam logic [4:0] OP_CLR_M = 5'h09;
  localparam logic [4:0] OP_CLR_BIT = 5'h0A;
  localparam logic [4:0] OP_CLR_WDT = 5'h0B;
  localparam logic [4:0] OP_PRE1 = 5'h0C;
  localparam logic [4:0] OP_PRE2 = 5'h0D;
  localparam logic [4:0] OP_CPL = 5'h0E;
  localparam logic [4:0] OP_INVERT_TO_WORKING_OP = 5'h0F;
  localparam logic [4:0] OP_DAA = 5'h10;
  localparam logic [4:0] OP_DEC = 5'h11;
  localparam logic [4:0] OP_DECREMENT_TO_WORKING_OP = 5'h12;
  localparam logic [4:0] OP_INC = 5'h13;
  localparam logic [4:0] OP_INCREMENT_TO_WORKING_OP = 5'h14;
  localparam logic [4:0] OP_MOV_AM = 5'h15;
  localparam logic [4:0] OP_MOV_AI = 5'h16;
  localparam logic [4:0] OP_MOV_MA = 5'h17;
  localparam logic [4:0] OP_HALT = 5'h18;

  typedef enum logic [2:0] {
    MIEX_IDLE = 3'b001,
    MIEX_EXEC = 3'b010,
    MIEX_HALT = 3'b100
  } miex_state_e;

endpackage

// [logic/miex_core.sv]
// Instruction execute unit with data memory, stack, flags and watchdog behind an Avalon-MM slave.
// Function
// - AND with memory operand puts result in working register, only zero flag.
// - AND with immediate puts result in working register, only zero flag.
// - AND into memory stores result in memory, working register kept, zero flag.
// - Call pushes next address on stack then loads target, no flags.
// - Byte clear writes zero to memory, no flags.
// - Bit clear zeroes one selected memory bit only, no flags.
// - Direct watchdog clear zeroes counter and clears power-down and expired flags.
// - Both preclear instructions together clear counter and both flags.
// - A lone preclear only records itself; counter and flags stay.
// - Invert memory flips every bit in place, only zero flag.
// - Invert to working loads inverted byte, memory kept, zero flag.
// - Adjust adds six to low nibble above nine or half carry set.
// - Adjust high nibble with nibble carry, sets carry, result to memory.
// - Decrement subtracts one into memory or working register, zero flag.
// - Increment adds one into memory or working register, zero flag.
// - Power-down stops execution, keeps state, advances program counter by one.
// - Power-down clears counter and prescaler, sets power-down, clears expired flag.
// - Jump loads the program counter with the target, no flags.
// - Moves copy memory to working register or back, no flags.
// - Move immediate loads the eight-bit constant into working register.
// - No-operation only advances the program counter by one.
// - OR with memory or immediate into working register, only zero flag.
// - Writing the program counter low byte costs one more four-clock cycle.
`timescale 1ns/1ps

module miex_core
  import miex_pkg::*;
#(
  parameter int MEM_DEPTH = 64,
  parameter int STACK_DEPTH = 16,
  parameter int WDT_PRESC = 256
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  function automatic logic zf(input logic [7:0] v);
    return v == BYTE_ZERO;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  miex_state_e st_r;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [PC_W-1:0] stk_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0] acc_r;
  logic [7:0] maddr_r;
  logic [PC_W-1:0] tgt_r;
  logic z_r, c_r, ac_r, ov_r, pdf_r, to_r, pre1_r, pre2_r;
  logic [7:0] wdt_r;
  logic [15:0] presc_r;
  logic [3:0] busy_r;
  logic rd_ack_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire sel_cmd = avs_address == OFF_CMD;
  wire sel_opnd = avs_address == OFF_OPND;
  wire sel_acc = avs_address == OFF_ACC;
  wire sel_stat = avs_address == OFF_STATUS;
  wire sel_pc = avs_address == OFF_PC;
  wire sel_wdt = avs_address == OFF_WDT;
  wire sel_stk = avs_address == OFF_STACK;
  wire sel_mem = avs_address[9:8] == MEM_PAGE;
  wire [MADDR_W-1:0] bus_idx = avs_address[MADDR_W+1:2];
  // A command write while an instruction is still running is stalled, not dropped.
  wire cmd_stall = avs_write & sel_cmd & (st_r == MIEX_EXEC);
  wire go = avs_write & sel_cmd & (st_r == MIEX_IDLE);
  wire bus_wr = avs_write & ~cmd_stall;

  assign avs_waitrequest = (avs_read & ~rd_ack_r) | cmd_stall;
  assign avs_readdata = rdata_r;

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  wire [4:0] op = avs_writedata[CMD_OP_LSB+4:CMD_OP_LSB];
  wire [2:0] bsel = avs_writedata[CMD_BIT_LSB+2:CMD_BIT_LSB];
  wire [7:0] imm = avs_writedata[CMD_IMM_LSB+7:CMD_IMM_LSB];
  wire [MADDR_W-1:0] midx = maddr_r[MADDR_W-1:0];
  wire [7:0] mval = mem_r[midx];
  wire [PC_W-1:0] pc_inc = pc_r + 1'b1;
  wire [3:0] lo_nib = acc_r[3:0];
  wire lo_adj = (lo_nib > NIB_LIMIT) | ac_r;
  wire [4:0] lo_sum = {1'b0, lo_nib} + NIB_ADJ;
  wire nib_carry = lo_adj & lo_sum[4];
  wire [4:0] hi_base = {1'b0, acc_r[7:4]} + {4'h0, nib_carry};
  wire hi_adj = (hi_base > {1'b0, NIB_LIMIT}) | c_r;
  wire [4:0] hi_sum = hi_base + NIB_ADJ;
  wire [7:0] daa_res = {hi_adj ? hi_sum[3:0] : hi_base[3:0], lo_adj ? lo_sum[3:0] : lo_nib};

  // ----------------------------------------------------------------
  // Execute decode
  // ----------------------------------------------------------------
  logic [7:0] res;
  logic wr_acc, wr_mem, upd_z, two_cyc;

  always_comb
  begin
    res = BYTE_ZERO;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    two_cyc = 1'b0;
    case (op)
      OP_AND_M: begin res = acc_r & mval; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_AND_I: begin res = acc_r & imm; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_AND_INTO_MEMORY_OP: begin res = acc_r & mval; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_OR_M: begin res = acc_r | mval; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_OR_I: begin res = acc_r | imm; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_ORM: begin res = acc_r | mval; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_CALL: two_cyc = 1'b1;
      OP_JMP: two_cyc = 1'b1;
      OP_CLR_M: begin res = BYTE_ZERO; wr_mem = 1'b1; end
      OP_CLR_BIT: begin res = mval & ~(8'h01 << bsel); wr_mem = 1'b1; end
      OP_CPL: begin res = ~mval; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_INVERT_TO_WORKING_OP: begin res = ~mval; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_DAA: begin res = daa_res; wr_mem = 1'b1; end
      OP_DEC: begin res = mval - 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_DECREMENT_TO_WORKING_OP: begin res = mval - 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_INC: begin res = mval + 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end
      OP_INCREMENT_TO_WORKING_OP: begin res = mval + 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end
      OP_MOV_AM: begin res = mval; wr_acc = 1'b1; end
      OP_MOV_AI: begin res = imm; wr_acc = 1'b1; end
      OP_MOV_MA: begin res = acc_r; wr_mem = 1'b1; end
      default: res = BYTE_ZERO;
    endcase
  end

  wire wr_pcl = wr_mem & (midx == PCL_IDX);
  wire is_halt = op == OP_HALT;
  // Machine cycles: one, plus one for a branch, plus one for a low-byte write.
  wire [1:0] ncyc = 2'h1 + {1'b0, two_cyc} + {1'b0, wr_pcl};
  wire [3:0] busy_ld = 4'({ncyc, 2'b00} - 4'h1);

  logic [PC_W-1:0] pc_nxt;
  always_comb
  begin
    pc_nxt = pc_inc;
    if (op == OP_CALL || op == OP_JMP)
      pc_nxt = tgt_r;
    else if (wr_pcl)
      pc_nxt = {pc_r[PC_W-1:8], res};
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  wire presc_tick = presc_r == 16'(WDT_PRESC - 1);
  wire wdt_ovf = presc_tick & (wdt_r == 8'hFF);
  wire pair_done = (op == OP_PRE1 & pre2_r) | (op == OP_PRE2 & pre1_r);
  wire wdt_clr = go & ((op == OP_CLR_WDT) | pair_done | is_halt);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_r <= 16'h0000;
      wdt_r <= BYTE_ZERO;
    end
    else if (wdt_clr)
    begin
      presc_r <= 16'h0000;
      wdt_r <= BYTE_ZERO;
    end
    else
    begin
      presc_r <= presc_tick ? 16'h0000 : presc_r + 16'h0001;
      wdt_r <= presc_tick ? wdt_r + 8'h01 : wdt_r;
    end
  end

  // The expired flag set by an overflow wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      to_r <= 1'b0;
      pdf_r <= 1'b0;
      pre1_r <= 1'b0;
      pre2_r <= 1'b0;
    end
    else
    begin
      if (go && (op == OP_CLR_WDT || pair_done))
      begin
        to_r <= 1'b0;
        pdf_r <= 1'b0;
        pre1_r <= 1'b0;
        pre2_r <= 1'b0;
      end
      else if (go && op == OP_PRE1)
        pre1_r <= 1'b1;
      else if (go && op == OP_PRE2)
        pre2_r <= 1'b1;
      else if (go && is_halt)
      begin
        to_r <= 1'b0;
        pdf_r <= 1'b1;
      end
      if (wdt_ovf)
        to_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer; a watchdog overflow or a wake write ends power-down
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= MIEX_IDLE;
      busy_r <= 4'h0;
    end
    else
    begin
      case (st_r)
        MIEX_IDLE:
        begin
          if (go && is_halt)
            st_r <= MIEX_HALT;
          else if (go)
          begin
            st_r <= MIEX_EXEC;
            busy_r <= busy_ld;
          end
        end
        MIEX_EXEC:
        begin
          busy_r <= busy_r - 4'h1;
          if (busy_r == 4'h1)
            st_r <= MIEX_IDLE;
        end
        MIEX_HALT:
        begin
          if (wdt_ovf || (bus_wr && sel_stat && avs_writedata[ST_HALT]))
            st_r <= MIEX_IDLE;
        end
        default: st_r <= MIEX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Datapath and architectural registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= BYTE_ZERO;
      {z_r, c_r, ac_r, ov_r} <= 4'h0;
      pc_r <= '0;
      sp_r <= '0;
      maddr_r <= BYTE_ZERO;
      tgt_r <= '0;
      for (int i = 0; i < MEM_DEPTH; i++)
        mem_r[i] <= BYTE_ZERO;
      for (int i = 0; i < STACK_DEPTH; i++)
        stk_r[i] <= '0;
    end
    else if (go)
    begin
      pc_r <= pc_nxt;
      if (wr_acc)
        acc_r <= res;
      if (wr_mem)
        mem_r[midx] <= res;
      if (upd_z)
        z_r <= zf(res);
      if (op == OP_DAA && hi_adj)
        c_r <= 1'b1;
      if (op == OP_CALL)
      begin
        stk_r[sp_r] <= pc_inc;
        sp_r <= sp_r + 1'b1;
      end
    end
    else if (bus_wr)
    begin
      if (sel_opnd)
      begin
        maddr_r <= avs_writedata[OPND_ADDR_LSB+7:OPND_ADDR_LSB];
        tgt_r <= avs_writedata[OPND_TGT_LSB+PC_W-1:OPND_TGT_LSB];
      end
      if (sel_acc)
        acc_r <= avs_writedata[7:0];
      if (sel_stat)
        {ov_r, ac_r, c_r, z_r} <= avs_writedata[ST_OV:ST_Z];
      if (sel_pc)
        pc_r <= avs_writedata[PC_W-1:0];
      if (sel_mem)
        mem_r[bus_idx] <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path: one wait state, then registered data
  // ----------------------------------------------------------------
  wire [SP_W-1:0] sp_top = sp_r - 1'b1;
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_opnd)
      rd_mux = {4'h0, tgt_r, 8'h00, maddr_r};
    else if (sel_acc)
      rd_mux = {24'h00_0000, acc_r};
    else if (sel_stat)
      rd_mux = {20'h0_0000, pre2_r, pre1_r, st_r == MIEX_HALT, st_r == MIEX_EXEC,
                2'b00, to_r, pdf_r, ov_r, ac_r, c_r, z_r};
    else if (sel_pc)
      rd_mux = {12'h000, sp_r, 4'h0, pc_r};
    else if (sel_wdt)
      rd_mux = {24'h00_0000, wdt_r};
    else if (sel_stk)
      rd_mux = {20'h0_0000, stk_r[sp_top]};
    else if (sel_mem)
      rd_mux = {24'h00_0000, mem_r[bus_idx]};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_read && !rd_ack_r)
        rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_and_imm_result: assert property (go && op == OP_AND_I |=>
    acc_r == ($past(acc_r) & $past(imm)) && z_r == (acc_r == BYTE_ZERO))
    else $error("and immediate result or zero flag wrong");
  a_and_into_memory_op_keeps_acc: assert property (go && op == OP_AND_INTO_MEMORY_OP && !wr_pcl |=>
    acc_r == $past(acc_r) && mem_r[$past(midx)] == ($past(acc_r) & $past(mval)))
    else $error("and into memory wrong");
  a_call_push_load: assert property (go && op == OP_CALL |=>
    pc_r == $past(tgt_r) && stk_r[sp_top] == $past(pc_inc) && z_r == $past(z_r))
    else $error("call did not push or load");
  a_clr_mem_zero: assert property (go && op == OP_CLR_M |=>
    mem_r[$past(midx)] == BYTE_ZERO && c_r == $past(c_r))
    else $error("memory clear failed");
  a_pre_single_hold: assert property (go && op == OP_PRE1 && !pre2_r && !wdt_ovf |=>
    to_r == $past(to_r) && pdf_r == $past(pdf_r) && pre1_r &&
    ($past(presc_tick) || presc_r == 16'($past(presc_r) + 16'h0001)))
    else $error("lone preclear changed watchdog state");
  a_pre_pair_clear: assert property (go && op == OP_PRE2 && pre1_r && !wdt_ovf |=>
    wdt_r == BYTE_ZERO && !to_r && !pdf_r && !pre1_r)
    else $error("preclear pair did not clear");
  a_halt_entry: assert property (go && is_halt && !wdt_ovf |=>
    pdf_r && !to_r && wdt_r == BYTE_ZERO && st_r == MIEX_HALT && pc_r == $past(pc_inc))
    else $error("power-down entry wrong");
  a_jmp_two_cycles: assert property (go && op == OP_JMP |=>
    st_r == MIEX_EXEC [*7] ##1 st_r == MIEX_IDLE)
    else $error("jump did not take two machine cycles");
  a_pcl_extra_cycle: assert property (go && wr_pcl |=>
    st_r == MIEX_EXEC [*7] ##1 st_r == MIEX_IDLE)
    else $error("low byte write missed extra cycle");
  a_increment_to_working_op_result: assert property (go && op == OP_INCREMENT_TO_WORKING_OP |=>
    acc_r == 8'($past(mval) + 8'h01) && mem_r[$past(midx)] == $past(mval))
    else $error("increment to working wrong");
  a_daa_carry_sticky: assert property (go && op == OP_DAA && c_r |=> c_r)
    else $error("adjust cleared carry");

  c_call_seen: cover property (go && op == OP_CALL);
  c_halt_wake: cover property (st_r == MIEX_HALT ##[1:300] st_r == MIEX_IDLE);
  c_pre_pair: cover property (go && op == OP_PRE2 && pre1_r);
  c_daa_both: cover property (go && op == OP_DAA && lo_adj && hi_adj);

endmodule

// [dv/miex_core_tb.sv]
// Self-checking bench for the instruction execute unit against a reference model.
`timescale 1ns/1ps

module mcu_instruction_execute_subset_tb_top
  import miex_pkg::*;
;
  logic core_clk;
  logic arst_n;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  int err_total;
  int checks_done;
  int seed;
  int acc, pc, z, c, ac, ov, powerdown_flag, to, p1, p2, hlt;
  int mem[64];
  int stk[$];

  // A prescaler of 512, twice the default, keeps the watchdog visible without letting it overflow in the run.
  miex_core #(.WDT_PRESC(512)) i_miex_core (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wait_ack(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (n > 60)
      begin
        err_total++;
        report_and_stop();
      end
    end while (avs_waitrequest !== 1'b0);
    n--;
  endtask

  // Requests stay asserted after the answer; callers release them with bus_idle before waiting.
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d, output int n);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    avs_read <= 1'b0;
    wait_ack(n);
  endtask

  task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
    int n;
    avs_address <= a;
    avs_read <= 1'b1;
    avs_write <= 1'b0;
    wait_ack(n);
    d = avs_readdata;
  endtask

  task automatic bus_idle(input int k);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (k) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  task automatic model(input int op, input int b, input int x, input int i, input int t,
                       output int n);
    int m, r, lo, hi, a1, wa, wm, zu, npc;
    m = mem[i];
    n = 1;
    npc = (pc + 1) & 4095;
    case (5'(op))
      OP_AND_M, OP_AND_I, OP_AND_INTO_MEMORY_OP: r = acc & ((5'(op) == OP_AND_I) ? x : m);
      OP_OR_M, OP_OR_I, OP_ORM: r = acc | ((5'(op) == OP_OR_I) ? x : m);
      OP_CPL, OP_INVERT_TO_WORKING_OP: r = ~m & 255;
      OP_DEC, OP_DECREMENT_TO_WORKING_OP: r = (m + 255) & 255;
      OP_INC, OP_INCREMENT_TO_WORKING_OP: r = (m + 1) & 255;
      OP_MOV_AM: r = m;
      OP_MOV_AI: r = x;
      OP_MOV_MA: r = acc;
      OP_CLR_BIT: r = m & ~(1 << b);
      default: r = 0;
    endcase
    wa = 5'(op) inside {OP_AND_M, OP_AND_I, OP_OR_M, OP_OR_I, OP_INVERT_TO_WORKING_OP, OP_DECREMENT_TO_WORKING_OP, OP_INCREMENT_TO_WORKING_OP,
                        OP_MOV_AM, OP_MOV_AI};
    wm = 5'(op) inside {OP_AND_INTO_MEMORY_OP, OP_ORM, OP_CPL, OP_DEC, OP_INC, OP_MOV_MA, OP_CLR_BIT,
                        OP_CLR_M, OP_DAA};
    zu = 5'(op) inside {OP_AND_M, OP_AND_I, OP_AND_INTO_MEMORY_OP, OP_OR_M, OP_OR_I, OP_ORM, OP_CPL,
                        OP_INVERT_TO_WORKING_OP, OP_DEC, OP_DECREMENT_TO_WORKING_OP, OP_INC, OP_INCREMENT_TO_WORKING_OP};
    if (5'(op) == OP_DAA)
    begin
      lo = acc & 15;
      hi = acc >> 4;
      a1 = 0;
      if (lo > 9 || ac != 0)
      begin
        lo = lo + 6;
        a1 = lo >> 4;
      end
      hi = hi + a1;
      if (hi > 9 || c != 0)
      begin
        hi = hi + 6;
        c = 1;
      end
      r = ((hi & 15) << 4) | (lo & 15);
    end
    if (wa != 0)
      acc = r;
    if (zu != 0)
      z = (r == 0);
    if (wm != 0)
      mem[i] = r;
    if (wm != 0 && i == 2)
    begin
      npc = (npc & 3840) | r;
      n++;
    end
    if (5'(op) == OP_CALL)
      stk.push_back(npc);
    if (5'(op) == OP_CALL || 5'(op) == OP_JMP)
    begin
      npc = t;
      n = 2;
    end
    if (5'(op) == OP_HALT)
    begin
      powerdown_flag = 1;
      to = 0;
      hlt = 1;
    end
    if (5'(op) == OP_CLR_WDT || (5'(op) == OP_PRE1 && p2 != 0) || (5'(op) == OP_PRE2 && p1 != 0))
    begin
      powerdown_flag = 0;
      to = 0;
      p1 = 0;
      p2 = 0;
    end
    else if (5'(op) == OP_PRE1)
      p1 = 1;
    else if (5'(op) == OP_PRE2)
      p2 = 1;
    pc = npc;
  endtask

  task automatic check_state(input int i);
    logic [31:0] e;
    bus_rd(OFF_ACC, rd);
    chk("acc", 32'(acc), {24'h0, rd[7:0]});
    bus_rd(OFF_STATUS, rd);
    e = {20'h0, 1'(p2), 1'(p1), 1'(hlt), 3'h0, 1'(to), 1'(powerdown_flag), 1'(ov), 1'(ac), 1'(c), 1'(z)};
    chk("status", e, {20'h0, rd[11:0]});
    bus_rd(OFF_PC, rd);
    chk("pc", 32'(pc), {20'h0, rd[11:0]});
    bus_rd(OFF_STACK, rd);
    chk("stack", (stk.size() > 0) ? 32'(stk[$]) : 32'h0, {20'h0, rd[11:0]});
    if (i != 2)
    begin
      bus_rd(10'(256 + 4 * i), rd);
      chk("mem", 32'(mem[i]), {24'h0, rd[7:0]});
    end
  endtask

  // A trailing no-operation is stalled until the first instruction ends, which times it; after power-down entry it is dropped unstalled.
  task automatic run_op(input int op, input int b, input int x, input int i, input int t);
    int n, w, d;
    model(op, b, x, i, t, n);
    bus_wr(OFF_OPND, {4'h0, 12'(t), 8'h0, 8'(i)}, w);
    bus_wr(OFF_CMD, {8'h0, 8'(x), 5'h0, 3'(b), 3'h0, 5'(op)}, w);
    bus_wr(OFF_CMD, {27'h0, OP_NOP}, w);
    chk("stall", (hlt != 0) ? 32'h0 : 32'(4 * n - 1), 32'(w));
    if (hlt == 0)
      model(OP_NOP, 0, 0, i, 0, d);
    bus_idle(4);
    check_state(i);
  endtask

  task automatic wake;
    int w;
    bus_wr(OFF_STATUS, 32'(512 + z + 2 * c + 4 * ac + 8 * ov), w);
    hlt = 0;
    bus_idle(1);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    int k, op, i, v, f, w;
    seed = 32'hFED0;
    {acc, pc, z, c, ac, ov, powerdown_flag, to, p1, p2, hlt} = '0;
    foreach (mem[j]) mem[j] = 0;
    arst_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_state(5);
    bus_wr(10'h3F0, 32'hA5A5_A5A5, w);
    bus_rd(10'h3F0, rd);
    chk("unmapped", 32'h0, rd);
    for (k = 0; k < 48; k++)
    begin
      op = k % 24;
      if (op >= 11 && op <= 13)
        op = 16;
      i = 4 + ({$random(seed)} % 60);
      v = (k % 4 == 0) ? 255 : ((k % 4 == 1) ? 1 : ($random(seed) & 255));
      mem[i] = v;
      bus_wr(10'(256 + 4 * i), 32'(v), w);
      acc = $random(seed) & 255;
      bus_wr(OFF_ACC, 32'(acc), w);
      f = $random(seed) & 15;
      {ov, ac, c, z} = {31'h0, f[3], 31'h0, f[2], 31'h0, f[1], 31'h0, f[0]};
      bus_wr(OFF_STATUS, 32'(f), w);
      run_op(op, $random(seed) & 7, $random(seed) & 255, i, $random(seed) & 4095);
    end
    run_op(OP_CLR_M, 0, 0, 2, 0);
    run_op(OP_INC, 0, 0, 2, 0);
    bus_idle(3 * 512);
    run_op(OP_HALT, 0, 0, 6, 0);
    bus_rd(OFF_WDT, rd);
    chk("wdt_halt", 32'h0, rd);
    wake();
    bus_idle(3 * 512);
    run_op(OP_PRE1, 0, 0, 6, 0);
    bus_rd(OFF_WDT, rd);
    chk("wdt_lone", 32'h1, 32'(rd[7:0] != 8'h00));
    run_op(OP_PRE2, 0, 0, 6, 0);
    bus_rd(OFF_WDT, rd);
    chk("wdt_pair", 32'h0, rd);
    run_op(OP_HALT, 0, 0, 6, 0);
    wake();
    run_op(OP_PRE2, 0, 0, 6, 0);
    run_op(OP_CLR_WDT, 0, 0, 6, 0);
    bus_rd(OFF_WDT, rd);
    chk("wdt_clear", 32'h0, rd);
    report_and_stop();
  end
endmodule
